// file: bench/dicd_contacts.sv
module dicd_contacts
(
   input wire logic        clk_sys_i,
   input wire logic [3:0]  want_i,
   input wire logic        bounce_i,
   input wire logic [3:0]  noise_i,
   output logic [3:0]      terminal_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] last = 4'h0;
   logic [3:0] moving = 4'h0;
   logic [2:0] left = 3'h0;

   // Real contacts chatter for a few cycles after every change
   always_ff @(posedge clk_sys_i)
   begin
      if (want_i != last)
      begin
         moving <= want_i ^ last;
         left <= 3'h5;
      end
      else if (left != 3'h0)
         left <= left - 3'h1;
      last <= want_i;
      terminal_o <= (bounce_i && left != 3'h0) ? want_i ^ (moving & noise_i) : want_i;
   end
endmodule

// file: bench/dicd_decoder_sva.sv
module dicd_decoder_sva
   import dicd_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [7:0]  paddr_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        run_o,
   input wire logic        reverse_o,
   input wire logic        fast_stop_o,
   input wire logic        trip_o,
   input wire logic        external_fault_display_o,
   input wire logic        thermistor_fault_display_o,
   input wire logic        fire_mode_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   // ---------------------------------------------
   // Bus access steps
   // ---------------------------------------------
   wire logic bad_addr = (paddr_i > ADDR_CMD) || (paddr_i[1:0] != 2'b00);
   sequence seq_taken;
      ce_i && psel_i && penable_i && !pready_o;
   endsequence

   chk_apb_wait: assert property (seq_taken |=> pready_o)
      else $error("access not answered after one wait state");
   chk_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   chk_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
      else $error("ready without an access");
   chk_slverr_unmapped: assert property (seq_taken ##0 bad_addr |=> pslverr_o)
      else $error("unmapped access not refused");
   chk_slverr_mapped: assert property (seq_taken ##0 !bad_addr |=> pready_o && !pslverr_o)
      else $error("mapped access refused");

   // ---------------------------------------------
   // Drive command outputs
   // ---------------------------------------------
   chk_reset_quiet: assert property ($past(rst_i) && $past(ce_i) |->
      !run_o && !reverse_o && !fast_stop_o && !trip_o && !fire_mode_o)
      else $error("command outputs not cleared by reset");
   chk_freeze_ce: assert property (!ce_i |=>
      $stable({run_o, reverse_o, fast_stop_o, trip_o, fire_mode_o}))
      else $error("outputs moved while clock enable low");
   chk_fault_code: assert property (external_fault_display_o || thermistor_fault_display_o |->
      trip_o && !(external_fault_display_o && thermistor_fault_display_o))
      else $error("fault display without single trip code");
   chk_trip_halts: assert property (trip_o |=> !run_o)
      else $error("drive runs while tripped");
   chk_fstop_halts: assert property ($rose(fast_stop_o) |=> !run_o)
      else $error("fast stop did not stop the drive");
endmodule

// file: bench/tb_top.sv
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
   $display("BAD %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dicd_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic [3:0]  want = 4'h2;
   logic        bounce = 1'b0;
   logic [31:0] noise = 32'h0;
   logic        enable = 1'b0;
   logic [15:0] ai1 = 16'h0;
   logic [15:0] ai2 = 16'h0;
   logic [15:0] ai2_q = 16'h0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rd;
   logic        err;
   wire  [3:0]  terminal;
   wire  [31:0] prdata;
   wire         pready, pslverr, run, reverse, fstop, trip, ext, therm, fire;
   wire  [15:0] demand, pfb;
   int          err_count = 0;
   int          tests_run = 0;
   int          seed = 32'h91B6;
   int          model_reg[6];

   always #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i)
   begin
      noise <= $random(seed);
      ai1 <= noise[15:0];
      ai2 <= noise[31:16];
      ai2_q <= ai2;
   end

   dicd_contacts dicd_contacts_i (.clk_sys_i(clk_sys_i), .want_i(want), .bounce_i(bounce),
      .noise_i(noise[3:0]), .terminal_o(terminal));

   dicd_decoder #(.DEB(8)) dicd_decoder_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
      .terminal_i(terminal), .enable_i(enable), .analog_in_one_i(ai1),
      .analog_in_two_i(ai2), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .run_o(run), .reverse_o(reverse), .fast_stop_o(fstop),
      .trip_o(trip), .external_fault_display_o(ext), .thermistor_fault_display_o(therm),
      .fire_mode_o(fire), .speed_demand_o(demand), .process_feedback_o(pfb));

   // ---------------------------------------------
   // Bus master and helpers
   // ---------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      `CHK("ready", 1'b1, pready)
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      settle(6);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1 `CHK("outs_rst", 7'h0, {run, reverse, fstop, trip, ext, therm, fire})
      for (int a = 0; a <= 24; a += 4)
      begin
         apb(1'b0, a[7:0], 32'h0);
         `CHK("reg_rst", 16'h0, rd[15:0])
      end
      for (int i = 0; i < 6; i++)
      begin
         model_reg[i] = $random(seed) & 16'hFFFF;
         apb(1'b1, 8'(4 * i + 4), 32'(model_reg[i]));
      end
      apb(1'b1, 8'h05, 32'h0000_1234);
      `CHK("err_unaligned", 1'b1, err)
      apb(1'b1, 8'h28, 32'h0000_1234);
      `CHK("err_unmapped", 1'b1, err)
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, 8'(4 * i + 4), 32'h0);
         `CHK("preset_rd", model_reg[i][15:0], rd[15:0])
         `CHK("err_mapped", 1'b0, err)
      end
      apb(1'b1, ADDR_CTRL, 32'h0000_0020);
      apb(1'b1, ADDR_CMD, 32'h0000_0002);
      settle(6);
      `CHK("fb_no_en", 1'b0, run)
      enable <= 1'b1;
      settle(6);
      apb(1'b1, ADDR_CMD, 32'h0000_0002);
      settle(6);
      `CHK("fb_run", 1'b1, run)
      `CHK("fieldbus_reference", model_reg[5][15:0], demand)
      enable <= 1'b0;
      settle(6);
      `CHK("fb_drop", 1'b0, run)
      apb(1'b1, ADDR_CTRL, 32'h0000_0010);
      enable <= 1'b1;
      settle(6);
      `CHK("kpd_wait", 1'b0, run)
      apb(1'b1, ADDR_CMD, 32'h0000_0001);
      settle(6);
      `CHK("kpd_run", 1'b1, run)
      `CHK("keypad_reference", model_reg[4][15:0], demand)
      ce_i <= 1'b0;
      enable <= 1'b0;
      settle(8);
      `CHK("ce_hold", 1'b1, run)
      ce_i <= 1'b1;
      settle(6);
      apb(1'b1, ADDR_CTRL, 32'h0000_0050);
      enable <= 1'b1;
      settle(6);
      `CHK("kpd_auto", 1'b1, run)
      enable <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h0000_0005);
      want <= 4'h7;
      settle(20);
      `CHK("lat_run", 1'b1, run)
      `CHK("fire", 1'b1, fire)
      `CHK("process_feedback", ai2_q, pfb)
      want <= 4'h5;
      settle(20);
      `CHK("nc_fstop", 1'b1, fstop)
      `CHK("fs_run", 1'b0, run)
      apb(1'b1, ADDR_CTRL, 32'h0000_0082);
      want <= 4'h1;
      settle(20);
      `CHK("trip_code", 3'b101, {trip, ext, therm})
      bounce <= 1'b1;
      // Every macro with chattering random contacts; checker judges
      for (int m = 0; m < 8; m++)
      begin
         apb(1'b1, ADDR_CTRL, 32'(m) | (32'($random(seed)) & 32'h80));
         apb(1'b1, ADDR_CMD, 32'h0000_0004);
         repeat (6)
         begin
            want <= 4'($random(seed));
            settle(30);
         end
      end
      tally_and_finish;
   end

   initial
   begin
      settle(60000);
      err_count++;
      tally_and_finish;
   end
endmodule

bind dicd_decoder dicd_decoder_sva sva_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
   .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .run_o(run_o), .reverse_o(reverse_o), .fast_stop_o(fast_stop_o),
   .trip_o(trip_o), .external_fault_display_o(external_fault_display_o),
   .thermistor_fault_display_o(thermistor_fault_display_o), .fire_mode_o(fire_mode_o));

// file: rtl/dicd_debounce.sv
module dicd_debounce
   import dicd_pkg::*;
#(
   parameter int N   = N_TERM,
   parameter int CNT = DEB_CNT
)(
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic [N-1:0] pin_i,
   dicd_term_if.filt       term
);
   logic [N-1:0] sync_a;
   logic [N-1:0] sync_b;
   logic [N-1:0] stable;

   // ------------------------------------------------------------
   // Two-flop sync, then per-terminal stability counter
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
      if (rst_i)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else if (ce_i)
      begin
         sync_a <= pin_i;
         sync_b <= sync_a;
      end

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_deb
         logic [$clog2(CNT+1)-1:0] cnt;
         logic                     differs;
         logic                     done;
         assign differs = sync_b[g] != stable[g];
         assign done    = differs && (cnt == ($clog2(CNT+1))'(CNT - 1));
         always_ff @(posedge clk_sys_i)
            if (rst_i)
            begin
               cnt       <= '0;
               stable[g] <= 1'b0;
            end
            else if (ce_i)
            begin
               cnt       <= (differs && !done) ? cnt + 1'b1 : '0;
               stable[g] <= done ? sync_b[g] : stable[g]; // RQ24
            end
         assign term.level[g] = stable[g];
         assign term.rise[g]  = done && sync_b[g];  // RQ24
         assign term.fall[g]  = done && !sync_b[g]; // RQ24
      end
   endgenerate
endmodule

// file: rtl/dicd_decoder.sv
// Contract
// RQ1: Latched stop open stops the drive regardless of run inputs; fb_run, and kpd_run in keypad mode, still run it with the stop open.
// RQ2: Latched run closed starts and keeps running; opening stops.
// RQ3: Latched forward and reverse select levels set rotation direction.
// RQ4: Latched run-forward runs forward while closed, stops when open.
// RQ5: Latched run-reverse runs reverse while closed, stops when open.
// RQ6: Keypad mode: enable starts directly or waits for keypad start key.
// RQ7: Other modes: fieldbus start ignored unless enable already asserted.
// RQ8: Start button rising edge starts, only while stop contact closed.
// RQ9: Paired start needs both inputs active together, stop held closed.
// RQ10: Edge stop contact opening (falling edge) stops the drive.
// RQ11: Start-forward rising edge starts forward if stop stays closed.
// RQ12: Start-reverse rising edge starts reverse if stop stays closed.
// RQ13: Both paired inputs active together give fast stop.
// RQ14: Fast-stop contact falling edge gives fast stop.
// RQ15: External trip opening trips; display code chosen by AI2 format.
// RQ16: Speed demand routed from AI1, AI2, preset, keypad or fieldbus.
// RQ17: Preset reference picks one of four presets by input code.
// RQ18: Normally-open acts on closure, normally-closed on opening.
// RQ19: Speed-up rising edge raises demand by preset one step.
// RQ20: Speed-down rising edge lowers demand by preset one step.
// RQ21: Process-feedback input goes to PI controller, not speed reference.
// RQ22: Fire-mode input asserted activates fire-mode state.
// RQ23: Macro setting decides every terminal's function.
// RQ24: Terminals synchronised and debounced; one edge per press.
// RQ25: Stop or fast stop beats start in the same sample.
//
// Our own choices: the register addresses and the APB register port.
module dicd_decoder
   import dicd_pkg::*;
#(
   parameter int RW  = REF_W,
   parameter int DEB = DEB_CNT
)(
   input  wire logic          clk_sys_i,
   input  wire logic          rst_i,
   input  wire logic          ce_i,
   input  wire logic [3:0]    terminal_i,
   input  wire logic          enable_i,
   input  wire logic [RW-1:0] analog_in_one_i,
   input  wire logic [RW-1:0] analog_in_two_i,
   input  wire logic          psel_i,
   input  wire logic          penable_i,
   input  wire logic          pwrite_i,
   input  wire logic [7:0]    paddr_i,
   input  wire logic [31:0]   pwdata_i,
   output logic [31:0]        prdata_o,
   output logic               pready_o,
   output logic               pslverr_o,
   output logic               run_o,
   output logic               reverse_o,
   output logic               fast_stop_o,
   output logic               trip_o,
   output logic               external_fault_display_o,
   output logic               thermistor_fault_display_o,
   output logic               fire_mode_o,
   output logic [RW-1:0]      speed_demand_o,
   output logic [RW-1:0]      process_feedback_o
);
   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [31:0]   ctrl;
   logic [RW-1:0] preset [4];
   logic [RW-1:0] keypad_reference;
   logic [RW-1:0] fieldbus_reference;
   logic [RW-1:0] step_acc;

   dicd_term_if #(.N(4)) term ();

   dicd_debounce #(.N(4), .CNT(DEB)) u_deb (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .pin_i     (terminal_i),
      .term      (term)
   );

   logic enable_s1;
   logic enable_s2;
   always_ff @(posedge clk_sys_i)
      if (rst_i)
      begin
         enable_s1 <= 1'b0;
         enable_s2 <= 1'b0;
      end
      else if (ce_i)
      begin
         enable_s1 <= enable_i;
         enable_s2 <= enable_s1;
      end

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire         acc       = psel_i && penable_i && !pready_o;
   wire         wr        = acc && pwrite_i;
   wire         hit_cmd   = paddr_i == ADDR_CMD;
   wire [2:0]   macro     = ctrl[CTRL_MACRO_LSB +: CTRL_MACRO_W];
   wire [1:0]   mode_bits = ctrl[CTRL_MODE_LSB +: CTRL_MODE_W];
   wire         kpd_mode  = mode_bits == MODE_KEYPAD;
   wire         kpd_auto  = ctrl[CTRL_KPDSTART];
   wire         ai2_fmt   = ctrl[CTRL_AI2FMT];
   wire         kpd_start = wr && hit_cmd && pwdata_i[CMD_KPD_START];
   wire         fb_start  = wr && hit_cmd && pwdata_i[CMD_FB_START];
   wire         trip_clr  = wr && hit_cmd && pwdata_i[CMD_TRIP_CLR];
   wire         mapped    = (paddr_i[1:0] == 2'b00) && (paddr_i <= ADDR_CMD);
   wire [31:0]  status_word;

   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      unique case (a)
         ADDR_CTRL:    rd_mux = ctrl;
         ADDR_PRESET0: rd_mux = 32'(preset[0]);
         ADDR_PRESET1: rd_mux = 32'(preset[1]);
         ADDR_PRESET2: rd_mux = 32'(preset[2]);
         ADDR_PRESET3: rd_mux = 32'(preset[3]);
         ADDR_KPDREF:  rd_mux = 32'(keypad_reference);
         ADDR_FBREF:   rd_mux = 32'(fieldbus_reference);
         ADDR_STATUS:  rd_mux = status_word;
         ADDR_DEMAND:  rd_mux = 32'(speed_demand_o);
         default:      rd_mux = 32'h0000_0000;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Terminal meaning per macro
   // ------------------------------------------------------------
   wire [3:0] lv = term.level;
   wire [3:0] rs = term.rise;
   wire [3:0] fl = term.fall;

   // Macro 0: stop/run, fwd/rev, AI1 or preset, AI1
   // Macro 1: stop/run, fwd/rev, preset code on t2,t3
   // Macro 2: run fwd / run_reverse_level latched, t2 trip
   // Macro 3: edge start fwd, stop NC, start rev, paired fast stop
   // Macro 4: edge start, stop NC, speed up/down
   // Macro 5: stop/run, fast stop NC, fire mode, AI2 PI feedback
   // Macro 6: paired start on t0,t2, stop NC on t1, t3 trip
   // Macro 7: stop/run, t1 trip, preset on t2,t3 in every control mode
   wire m_latched = macro inside {3'd0, 3'd1, 3'd5, 3'd7};
   wire stop_nc   = lv[1];                                        // RQ18
   wire lat_run   = m_latched && lv[0];                           // RQ1 RQ2
   wire lat_fwd   = macro == 3'd2 && lv[0];                       // RQ4
   wire lat_rev   = macro == 3'd2 && lv[1];                       // RQ5
   wire dir_sel   = (macro inside {3'd0, 3'd1}) ? lv[1] : 1'b0;  // RQ3
   wire e_fwd     = macro == 3'd3 && rs[0] && stop_nc;            // RQ11
   wire e_rev     = macro == 3'd3 && rs[2] && stop_nc;            // RQ12
   wire e_start   = macro == 3'd4 && rs[0] && stop_nc;            // RQ8
   wire pair_go   = macro == 3'd6 && stop_nc && ((rs[0] && lv[2]) || (rs[2] && lv[0])); // RQ9
   wire e_stop    = (macro inside {3'd3, 3'd4, 3'd6}) && fl[1];   // RQ10
   wire pair_fs   = macro == 3'd3 && ((rs[0] && lv[2]) || (rs[2] && lv[0])); // RQ13
   wire nc_fs     = macro == 3'd5 && fl[1];                       // RQ14
   wire trip_pin  = (macro == 3'd2 && !lv[2]) || (macro == 3'd6 && !lv[3])
                  || (macro == 3'd7 && !lv[1]);                   // RQ15
   wire fire_in   = macro == 3'd5 && lv[2];                       // RQ22
   wire pifb_sel  = macro == 3'd5;                                // RQ21
   wire up_ev     = macro == 3'd4 && rs[2];                       // RQ19
   wire dn_ev     = macro == 3'd4 && rs[3];                       // RQ20
   wire [1:0] pr_code = (macro == 3'd1 || macro == 3'd7) ? lv[3:2] : 2'b00; // RQ17
   wire m_edge    = macro inside {3'd3, 3'd4, 3'd6};
   wire m_lat_dir = macro == 3'd2;
   wire any_stop  = e_stop || pair_fs || nc_fs;                   // RQ25
   wire any_start = e_fwd || e_rev || e_start || pair_go;

   // ------------------------------------------------------------
   // Reference source selection
   // ------------------------------------------------------------
   dicd_src_e src;
   always_comb
   begin
      if (kpd_mode || macro == 3'd7)
         src = (macro == 3'd7) ? SRC_PRESET : SRC_KEYPAD;
      else if (mode_bits == MODE_FIELDBUS)
         src = SRC_FIELDBUS;
      else if (macro == 3'd1 || (macro == 3'd0 && lv[2]))
         src = SRC_PRESET;
      else if (macro == 3'd6 && lv[2])
         src = SRC_AI2;
      else
         src = SRC_AI1;
   end

   logic [RW-1:0] next_demand;
   always_comb
   begin
      unique case (src)                                           // RQ16
         SRC_AI1:      next_demand = analog_in_one_i;
         SRC_AI2:      next_demand = analog_in_two_i;
         SRC_PRESET:   next_demand = preset[pr_code];
         SRC_KEYPAD:   next_demand = keypad_reference;
         SRC_FIELDBUS: next_demand = fieldbus_reference;
         default:      next_demand = analog_in_one_i;
      endcase
      if (macro == 3'd4)
         next_demand = step_acc;
   end

   // ------------------------------------------------------------
   // Run command
   // ------------------------------------------------------------
   logic edge_run;
   logic edge_rev;
   logic kpd_run;
   logic fb_run;
   wire  en_gate   = enable_s2;
   wire  kpd_go    = kpd_mode && en_gate && (kpd_auto || kpd_start); // RQ6
   wire  fb_go     = !kpd_mode && en_gate && fb_start;               // RQ7
   wire  next_run  = !trip_o && !fast_stop_o && (kpd_mode ? kpd_run :
                     m_edge ? edge_run : (m_lat_dir ? (lat_fwd || lat_rev)
                     : (lat_run && stop_nc)) || fb_run);           // RQ1
   wire  next_rev  = m_edge ? edge_rev : (m_lat_dir ? (lat_rev && !lat_fwd) : dir_sel); // RQ3
   wire  next_fs   = (pair_fs || nc_fs) ? 1'b1 : (any_start ? 1'b0 : fast_stop_o);

   // Trip code bit is high only while the thermistor code is shown
   assign status_word = {16'h0000, 5'h00, 3'(src), 1'b0, pifb_sel, fire_mode_o,
                         thermistor_fault_display_o, trip_o,
                         fast_stop_o, reverse_o, run_o};

   // ------------------------------------------------------------
   // Sequential state
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
      if (rst_i)
      begin
         edge_run <= 1'b0;
         edge_rev <= 1'b0;
         kpd_run  <= 1'b0;
         fb_run   <= 1'b0;
      end
      else if (ce_i)
      begin
         if (any_stop || !m_edge)                                 // RQ25
            edge_run <= 1'b0;
         else if (any_start)
            edge_run <= 1'b1;
         if (e_fwd)
            edge_rev <= 1'b0;
         else if (e_rev)
            edge_rev <= 1'b1;
         kpd_run <= kpd_mode && en_gate && (kpd_run || kpd_go);
         fb_run  <= !kpd_mode && en_gate && (fb_run || fb_go);
      end

   always_ff @(posedge clk_sys_i)
      if (rst_i)
         step_acc <= '0;
      else if (ce_i)
      begin
         if (up_ev && !dn_ev)
            step_acc <= step_acc + preset[0];                     // RQ19
         else if (dn_ev && !up_ev)
            step_acc <= (step_acc > preset[0]) ? step_acc - preset[0] : '0; // RQ20
      end

   always_ff @(posedge clk_sys_i)
      if (rst_i)
      begin
         run_o                      <= 1'b0;
         reverse_o                  <= 1'b0;
         fast_stop_o                <= 1'b0;
         trip_o                     <= 1'b0;
         external_fault_display_o   <= 1'b0;
         thermistor_fault_display_o <= 1'b0;
         fire_mode_o                <= 1'b0;
         speed_demand_o             <= '0;
         process_feedback_o         <= '0;
      end
      else if (ce_i)
      begin
         run_o          <= next_run;
         reverse_o      <= next_rev;
         fast_stop_o    <= next_fs;                               // RQ13 RQ14
         fire_mode_o    <= fire_in;                               // RQ22
         speed_demand_o <= next_demand;
         process_feedback_o <= pifb_sel ? analog_in_two_i : '0;   // RQ21
         // Trip is sticky; a new trip outranks a clear in the same cycle
         if (trip_pin)
         begin
            trip_o                     <= 1'b1;                   // RQ15
            external_fault_display_o   <= !ai2_fmt;
            thermistor_fault_display_o <= ai2_fmt;
         end
         else if (trip_clr)
         begin
            trip_o                     <= 1'b0;
            external_fault_display_o   <= 1'b0;
            thermistor_fault_display_o <= 1'b0;
         end
      end

   // ------------------------------------------------------------
   // APB slave: one wait state, pready registered
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
      if (rst_i)
      begin
         ctrl               <= CTRL_RESET;
         preset             <= '{default: '0};
         keypad_reference   <= '0;
         fieldbus_reference <= '0;
         pready_o           <= 1'b0;
         pslverr_o          <= 1'b0;
         prdata_o           <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         pready_o  <= acc;
         pslverr_o <= acc && !mapped;
         prdata_o  <= (acc && !pwrite_i) ? rd_mux(paddr_i) : 32'h0000_0000;
         if (wr)
         begin
            unique case (paddr_i)                                 // RQ23
               ADDR_CTRL:    ctrl               <= pwdata_i & 32'h0000_00FF;
               ADDR_PRESET0: preset[0]          <= pwdata_i[RW-1:0];
               ADDR_PRESET1: preset[1]          <= pwdata_i[RW-1:0];
               ADDR_PRESET2: preset[2]          <= pwdata_i[RW-1:0];
               ADDR_PRESET3: preset[3]          <= pwdata_i[RW-1:0];
               ADDR_KPDREF:  keypad_reference   <= pwdata_i[RW-1:0];
               ADDR_FBREF:   fieldbus_reference <= pwdata_i[RW-1:0];
               default:      ;
            endcase
         end
      end
endmodule

// file: rtl/dicd_pkg.sv
package dicd_pkg;
   // ------------------------------------------------------------
   // Register map (APB byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_PRESET0 = 8'h04;
   localparam logic [7:0] ADDR_PRESET1 = 8'h08;
   localparam logic [7:0] ADDR_PRESET2 = 8'h0C;
   localparam logic [7:0] ADDR_PRESET3 = 8'h10;
   localparam logic [7:0] ADDR_KPDREF  = 8'h14;
   localparam logic [7:0] ADDR_FBREF   = 8'h18;
   localparam logic [7:0] ADDR_STATUS  = 8'h1C;
   localparam logic [7:0] ADDR_DEMAND  = 8'h20;
   localparam logic [7:0] ADDR_CMD     = 8'h24;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTRL_MACRO_LSB  = 0;
   localparam int CTRL_MACRO_W    = 3;
   localparam int CTRL_MODE_LSB   = 4;
   localparam int CTRL_MODE_W     = 2;
   localparam int CTRL_KPDSTART   = 6;
   localparam int CTRL_AI2FMT     = 7;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Command register bits (write one to pulse)
   localparam int CMD_KPD_START = 0;
   localparam int CMD_FB_START  = 1;
   localparam int CMD_TRIP_CLR  = 2;

   // Status register fields
   localparam int ST_RUN     = 0;
   localparam int ST_REVERSE = 1;
   localparam int ST_FSTOP   = 2;
   localparam int ST_TRIP    = 3;
   localparam int ST_TCODE   = 4;
   localparam int ST_FIRE    = 5;
   localparam int ST_PIFB    = 6;
   localparam int ST_SRC_LSB = 8;

   localparam int REF_W   = 16;
   localparam int N_TERM  = 4;
   localparam int DEB_CNT = 16;

   // Control sources
   typedef enum logic [1:0] {MODE_TERMINAL, MODE_KEYPAD, MODE_FIELDBUS, MODE_PI}
      dicd_mode_e;
   // Speed reference sources
   typedef enum logic [2:0] {SRC_AI1, SRC_AI2, SRC_PRESET, SRC_KEYPAD, SRC_FIELDBUS}
      dicd_src_e;
endpackage

// file: rtl/dicd_term_if.sv
interface dicd_term_if #(parameter int N = 4);
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   modport filt (output level, output rise, output fall);
   modport user (input level, input rise, input fall);
endinterface
